// [core/sbp_map.svh]
// Constants of the serial boot programming port: codes, address windows and timing.
// Assumes it is included by bare name from every file that needs a constant.
`ifndef SBP_MAP_SVH
`define SBP_MAP_SVH
`define SBP_MATCH_ASYNC 8'h86
`define SBP_MATCH_SYNC 8'h30
`define SBP_CMD_ERASE 8'hf0
`define SBP_CMD_WRITE 8'h30
`define SBP_CMD_READ 8'h40
`define SBP_CMD_RAMLD 8'h60
`define SBP_CMD_SUM 8'h90
`define SBP_CMD_ID 8'hc0
`define SBP_CMD_STAT 8'hc3
`define SBP_CMD_EMU 8'hd0
`define SBP_CMD_SEC 8'hfa
`define SBP_SUM_CHECK 8'hff
`define SBP_STAT_SEC_BIT 0
`define SBP_BROM_LO 16'h1000
`define SBP_BROM_DHI 16'h17ff
`define SBP_BROM_CHI 16'h1fff
`define SBP_FLASH_LO 16'h8000
`define SBP_RAM_LO 16'h0060
`define SBP_RAM_HI 16'h083f
`define SBP_SYS_MHZ 125
`define SBP_SYNC_MAX_BPS 250000
`define SBP_SYNC_HALF_CYC ((`SBP_SYS_MHZ*1000000+2*`SBP_SYNC_MAX_BPS-1)/(2*`SBP_SYNC_MAX_BPS))
`define SBP_HOLD_NS 1000
`define SBP_HOLD_CYC ((`SBP_HOLD_NS*`SBP_SYS_MHZ+999)/1000)
`define SBP_SETUP_US 100
`define SBP_SETUP_CYC (`SBP_SETUP_US*`SBP_SYS_MHZ)
`define SBP_BAUD_BPS 115200
`define SBP_BAUD_DIV (`SBP_SYS_MHZ*1000000/`SBP_BAUD_BPS)
`endif

// [core/sbp_pkg.sv]
// Types shared by both ends of the serial boot programming port.
// Assumes nothing of its surroundings.
package sbp_pkg;
   typedef logic [7:0] sbp_byte_t;
   typedef enum logic [1:0] {SBP_LINK_NONE, SBP_LINK_SYNC, SBP_LINK_ASYNC} sbp_link_t;
   typedef enum logic [1:0] {D_OFF, D_STBY, D_CMD, D_TX} sbp_dst_t;
   typedef enum logic [1:0] {AB_IDLE, AB_L1, AB_H, AB_L2} sbp_ab_t;
   typedef enum logic [2:0] {H_IDLE, H_HOLD, H_SETUP, H_READY, H_ATX, H_SWAIT,
                             H_SBURST} sbp_hst_t;
endpackage : sbp_pkg

// [core/sbp_link_if.sv]
// Pins between the programming host and the device.
// Assumes the bench joins both ends through one instance; the data pins are shared
// by both link types, as on the device.
`timescale 1ns/1ps
interface sbp_link_if;
   logic rst_pin_b;
   logic mode_pin;
   logic async_rx_pin;
   logic sync_clock_in;
   logic async_tx_pin;
   modport dev  (input rst_pin_b, mode_pin, async_rx_pin, sync_clock_in,
                 output async_tx_pin);
   modport host (output rst_pin_b, mode_pin, async_rx_pin, sync_clock_in,
                 input async_tx_pin);
endinterface : sbp_link_if

// [core/sbp_sync.sv]
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit is a slow level or is qualified later; no bus coherence.
`timescale 1ns/1ps
module sbp_sync #(
   parameter int         W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_b,
   // Levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= INIT;
         q      <= INIT;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : sbp_sync

// [core/sbp_dev.sv]
// Device end: boot-mode entry, link selection, auto-bauding, command decode.
// Assumes clk_link is the device oscillator and every pin is asynchronous to it.
`timescale 1ns/1ps
`include "sbp_map.svh"
module sbp_dev #(
   parameter int        CW     = 18,
   parameter logic [7:0] ID_ROM = 8'h5a, // Arbitrary value.
   parameter logic [7:0] ID_RAM = 8'ha5  // Arbitrary value.
) (
   // Link clock and power-on reset
   input  wire logic          clk_link,
   input  wire logic          rst_b,
   // Link pins
   sbp_link_if.dev            lnk,
   // Session state
   output sbp_pkg::sbp_link_t link_mode,
   output logic [CW-1:0]      bit_cycles,
   output logic               security_on,
   // Command handoff
   output logic               cmd_valid,
   output sbp_pkg::sbp_byte_t cmd_code,
   input  wire logic [15:0]   flash_sum,
   // Address translation
   input  wire logic [15:0]   cpu_addr,
   output logic               brom_data_sel,
   output logic               brom_code_sel,
   output logic               flash_hit,
   output logic [14:0]        flash_ofs,
   output logic               ram_hit
);
   import sbp_pkg::*;

   // ==========================================================
   // Pin capture
   logic rpin_s, mode_s, rx_s, sclk_s;
   logic rpin_q, rx_q, sclk_q;
   logic sync_data_in;

   sbp_sync #(.W(4), .INIT(4'h3)) u_sync (
      .clk   (clk_link),
      .rst_b (rst_b),
      .d     ({lnk.rst_pin_b, lnk.mode_pin, lnk.async_rx_pin, lnk.sync_clock_in}),
      .q     ({rpin_s, mode_s, rx_s, sclk_s})
   );

   always_ff @(posedge clk_link or negedge rst_b) begin
      if (!rst_b) begin
         rpin_q <= 1'b0;
         rx_q   <= 1'b1;
         sclk_q <= 1'b1;
      end else begin
         rpin_q <= rpin_s;
         rx_q   <= rx_s;
         sclk_q <= sclk_s;
      end
   end

   assign sync_data_in = rx_s;
   wire in_reset  = ~rpin_s;
   wire boot_go   = rpin_s & ~rpin_q & mode_s;
   wire sclk_rise = sclk_s & ~sclk_q;
   wire sclk_fall = ~sclk_s & sclk_q;
   wire rx_fall   = ~rx_s & rx_q;
   wire rx_rise   = rx_s & ~rx_q;

   // ==========================================================
   // State
   sbp_dst_t      st_q;
   sbp_link_t     mode_q;
   logic [CW-1:0] per_q;
   logic          sec_q;
   logic [7:0]    rep_q [0:2];
   logic [1:0]    rep_i_q, rep_n_q;
   logic          tbusy_q;
   wire           m_sync  = (mode_q == SBP_LINK_SYNC);
   wire           m_async = (mode_q == SBP_LINK_ASYNC);

   // ==========================================================
   // Clocked slave receiver, sampling on the rising edge
   logic [7:0] ssh_q;
   logic [2:0] scnt_q;
   wire        s_done = sclk_rise & (scnt_q == 3'd7);
   wire [7:0]  s_byte = {sync_data_in, ssh_q[7:1]};

   always_ff @(posedge clk_link or negedge rst_b) begin
      if (!rst_b) begin
         ssh_q  <= 8'h00;
         scnt_q <= 3'h0;
      end else if (in_reset || st_q == D_OFF || m_async) begin
         scnt_q <= 3'h0;
      end else if (sclk_rise) begin
         ssh_q  <= s_byte;
         scnt_q <= scnt_q + 3'h1;
      end
   end

   // ==========================================================
   // Asynchronous receiver at the measured bit time
   logic          arun_q;
   logic [CW-1:0] acnt_q;
   logic [3:0]    abit_q;
   logic [7:0]    ash_q;
   wire           a_tick = arun_q & (acnt_q == '0);
   wire           a_done = a_tick & (abit_q == 4'd9) & rx_s;

   always_ff @(posedge clk_link or negedge rst_b) begin
      if (!rst_b) begin
         arun_q <= 1'b0;
         acnt_q <= '0;
         abit_q <= 4'h0;
         ash_q  <= 8'h00;
      end else if (!m_async || in_reset) begin
         arun_q <= 1'b0;
      end else if (!arun_q) begin
         arun_q <= rx_fall;
         acnt_q <= per_q >> 1;
         abit_q <= 4'h0;
      end else if (a_tick) begin
         acnt_q <= per_q - 1'b1;
         abit_q <= abit_q + 4'h1;
         if (abit_q == 4'd0 && rx_s) arun_q <= 1'b0;
         if (abit_q == 4'd9) arun_q <= 1'b0;
         if (abit_q != 4'd0 && abit_q != 4'd9) ash_q <= {rx_s, ash_q[7:1]};
      end else begin
         acnt_q <= acnt_q - 1'b1;
      end
   end

   wire       rx_done = m_async ? a_done : s_done;
   wire [7:0] rx_byte = m_async ? ash_q : s_byte;

   // ==========================================================
   // Auto-baud: the matching byte gives low 2, high 2, low 4 bit times
   sbp_ab_t       ab_q;
   logic [CW-1:0] ab_cnt_q, l1_q, h_q;
   wire [CW+1:0]  l1w    = {2'b00, l1_q};
   wire [CW+1:0]  q4     = l1w >> 2;
   wire [CW+1:0]  hw     = {2'b00, h_q};
   wire [CW+1:0]  l2w    = {2'b00, ab_cnt_q};
   wire [CW+1:0]  ab_sum = l1w + hw + l2w;
   wire           ab_ok  = (hw >= l1w - q4) && (hw <= l1w + q4) &&
                           (l2w >= (l1w << 1) - (q4 << 1)) && (l2w <= (l1w << 1) + (q4 << 1));
   wire           ab_hit = (st_q == D_STBY) && (ab_q == AB_L2) && rx_rise && ab_ok;
   // A high run far longer than the first low run means the line went idle after a
   // rejected byte, so the search restarts at the next start bit.
   wire           ab_long = (ab_q == AB_H) && (l2w > (l1w << 1));
   wire [CW-1:0]  ab_per = {1'b0, ab_sum[CW+1:3]};

   always_ff @(posedge clk_link or negedge rst_b) begin
      if (!rst_b) begin
         ab_q     <= AB_IDLE;
         ab_cnt_q <= '0;
         l1_q     <= '0;
         h_q      <= '0;
      end else if (st_q != D_STBY || sclk_rise || &ab_cnt_q || ab_long) begin
         ab_q     <= AB_IDLE;
         ab_cnt_q <= '0;
      end else begin
         ab_cnt_q <= ab_cnt_q + 1'b1;
         case (ab_q)
            AB_IDLE: begin
               ab_cnt_q <= '0;
               if (rx_fall) ab_q <= AB_L1;
            end
            AB_L1: if (rx_rise) begin
               l1_q     <= ab_cnt_q;
               ab_cnt_q <= '0;
               ab_q     <= AB_H;
            end
            AB_H: if (rx_fall) begin
               h_q      <= ab_cnt_q;
               ab_cnt_q <= '0;
               ab_q     <= AB_L2;
            end
            AB_L2: if (rx_rise) ab_q <= AB_IDLE;
            default: ab_q <= AB_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Command decode and reply bytes
   wire c_sum   = rx_byte == `SBP_CMD_SUM;
   wire c_id    = rx_byte == `SBP_CMD_ID;
   wire c_stat  = rx_byte == `SBP_CMD_STAT;
   wire c_sec   = rx_byte == `SBP_CMD_SEC;
   wire c_emu   = rx_byte == `SBP_CMD_EMU;
   wire c_flash = rx_byte == `SBP_CMD_ERASE || rx_byte == `SBP_CMD_WRITE ||
                  rx_byte == `SBP_CMD_READ || rx_byte == `SBP_CMD_RAMLD;
   wire c_ok    = c_flash | c_sum | c_id | c_stat | c_sec | c_emu;
   wire [7:0] stat_b = 8'(sec_q) << `SBP_STAT_SEC_BIT;
   wire [7:0] rep0 = c_sum ? `SBP_SUM_CHECK : rx_byte;
   wire [7:0] rep1 = c_sum ? flash_sum[15:8] : c_id ? ID_ROM : stat_b;
   wire [7:0] rep2 = c_sum ? flash_sum[7:0] : ID_RAM;
   wire [1:0] rep_last = (c_sum | c_id) ? 2'd2 : c_stat ? 2'd1 : 2'd0;

   // ==========================================================
   // Transmitter for both link types
   logic [CW-1:0] tcnt_q;
   logic [3:0]    tbit_q;
   logic [9:0]    tsh_q;
   logic          sfirst_q, tx_q;
   wire           t_tick  = tbusy_q & m_async & (tcnt_q == '0);
   wire           tx_done = m_sync ? (tbusy_q & s_done) : (t_tick & (tbit_q == 4'd9));
   wire           tx_load = (st_q == D_TX) & ~tbusy_q;
   wire           tx_d    = m_async ? (tbusy_q ? tsh_q[0] : 1'b1) :
                            m_sync  ? ((st_q == D_TX && tbusy_q) ? (sfirst_q | tsh_q[0]) :
                                       (st_q == D_CMD)) : 1'b1;

   always_ff @(posedge clk_link or negedge rst_b) begin
      if (!rst_b) begin
         tbusy_q  <= 1'b0;
         tcnt_q   <= '0;
         tbit_q   <= 4'h0;
         tsh_q    <= 10'h3ff;
         sfirst_q <= 1'b1;
         tx_q     <= 1'b1;
      end else begin
         tx_q <= tx_d;
         if (in_reset || tx_done) begin
            tbusy_q <= 1'b0;
         end else if (tx_load) begin
            tbusy_q  <= 1'b1;
            tcnt_q   <= per_q - 1'b1;
            tbit_q   <= 4'h0;
            sfirst_q <= 1'b1;
            tsh_q    <= m_sync ? {2'b11, rep_q[rep_i_q]} : {1'b1, rep_q[rep_i_q], 1'b0};
         end else if (t_tick) begin
            tcnt_q <= per_q - 1'b1;
            tbit_q <= tbit_q + 4'h1;
            tsh_q  <= {1'b1, tsh_q[9:1]};
         end else if (tbusy_q && m_async) begin
            tcnt_q <= tcnt_q - 1'b1;
         end else if (tbusy_q && sclk_fall) begin
            sfirst_q <= 1'b0;
            if (!sfirst_q) tsh_q <= {1'b1, tsh_q[9:1]};
         end
      end
   end

   // ==========================================================
   // Session sequencer
   always_ff @(posedge clk_link or negedge rst_b) begin
      if (!rst_b) begin
         st_q      <= D_OFF;
         mode_q    <= SBP_LINK_NONE;
         per_q     <= '0;
         sec_q     <= 1'b0;
         rep_i_q   <= 2'd0;
         rep_n_q   <= 2'd0;
         rep_q[0]  <= 8'h00;
         rep_q[1]  <= 8'h00;
         rep_q[2]  <= 8'h00;
         cmd_valid <= 1'b0;
         cmd_code  <= 8'h00;
      end else begin
         cmd_valid <= 1'b0;
         if (in_reset) begin
            st_q   <= D_OFF;
            mode_q <= SBP_LINK_NONE;
         end else begin
            case (st_q)
               D_OFF: if (boot_go) st_q <= D_STBY;
               D_STBY: if (ab_hit) begin
                  mode_q   <= SBP_LINK_ASYNC;
                  per_q    <= ab_per;
                  rep_q[0] <= `SBP_MATCH_ASYNC;
                  rep_n_q  <= 2'd0;
                  rep_i_q  <= 2'd0;
                  st_q     <= D_TX;
               end else if (s_done && s_byte == `SBP_MATCH_SYNC) begin
                  mode_q   <= SBP_LINK_SYNC;
                  rep_q[0] <= `SBP_MATCH_SYNC;
                  rep_n_q  <= 2'd0;
                  rep_i_q  <= 2'd0;
                  st_q     <= D_TX;
               end
               D_CMD: if (rx_done && c_ok) begin
                  rep_q[0]  <= rep0;
                  rep_q[1]  <= rep1;
                  rep_q[2]  <= rep2;
                  rep_n_q   <= rep_last;
                  rep_i_q   <= 2'd0;
                  cmd_valid <= c_flash;
                  cmd_code  <= rx_byte;
                  if (c_sec) sec_q <= 1'b1;
                  st_q      <= D_TX;
               end
               D_TX: if (tx_done) begin
                  if (rep_i_q == rep_n_q) st_q <= D_CMD;
                  else rep_i_q <= rep_i_q + 2'd1;
               end
               default: st_q <= D_OFF;
            endcase
         end
      end
   end

   // ==========================================================
   // Address windows; the boot ROM windows only while the boot loader is running
   wire boot_on = (st_q != D_OFF);

   always_ff @(posedge clk_link or negedge rst_b) begin
      if (!rst_b) begin
         brom_data_sel <= 1'b0;
         brom_code_sel <= 1'b0;
         flash_hit     <= 1'b0;
         flash_ofs     <= 15'h0000;
         ram_hit       <= 1'b0;
      end else begin
         brom_data_sel <= boot_on && cpu_addr >= `SBP_BROM_LO && cpu_addr <= `SBP_BROM_DHI;
         brom_code_sel <= boot_on && cpu_addr >= `SBP_BROM_LO && cpu_addr <= `SBP_BROM_CHI;
         flash_hit     <= cpu_addr >= `SBP_FLASH_LO;
         flash_ofs     <= cpu_addr[14:0];
         ram_hit       <= cpu_addr >= `SBP_RAM_LO && cpu_addr <= `SBP_RAM_HI;
      end
   end

   assign lnk.async_tx_pin = tx_q;
   assign link_mode        = mode_q;
   assign bit_cycles       = per_q;
   assign security_on      = sec_q;
endmodule : sbp_dev

// [core/sbp_host.sv]
// Host end: drives reset and mode, sends and receives bytes on either link type.
// Assumes the user issues requests only while ready is high.
`timescale 1ns/1ps
`include "sbp_map.svh"
module sbp_host #(
   parameter int SETUP_CYC = `SBP_SETUP_CYC,
   parameter int BAUD_DIV  = `SBP_BAUD_DIV
) (
   // System clock and reset
   input  wire logic          clk_sys,
   input  wire logic          rst_b,
   // Session control
   input  wire logic          start,
   input  wire logic          use_sync,
   output logic               ready,
   // Byte transfer
   input  wire logic          tx_req,
   input  sbp_pkg::sbp_byte_t tx_byte,
   input  wire logic          rx_req,
   output logic               rx_valid,
   output sbp_pkg::sbp_byte_t rx_byte,
   // Link pins
   sbp_link_if.host           lnk
);
   import sbp_pkg::*;

   // ==========================================================
   // Sequencer
   sbp_hst_t    st_q, nx;
   logic [23:0] cnt_q;
   logic [3:0]  bit_q;
   logic [9:0]  sh_q;
   logic [7:0]  rsh_q;
   logic        sm_q, rd_q, so_s, so_q;
   logic        rpin_q, mpin_q, dout_q, sclk_q;
   wire         cnt_z = (cnt_q == 24'h0);

   sbp_sync #(.W(1), .INIT(1'b1)) u_sync (
      .clk   (clk_sys),
      .rst_b (rst_b),
      .d     (lnk.async_tx_pin),
      .q     (so_s)
   );

   always_comb begin
      nx = st_q;
      case (st_q)
         H_IDLE:   if (start) nx = H_HOLD;
         H_HOLD:   if (cnt_z) nx = H_SETUP;
         H_SETUP:  if (cnt_z) nx = H_READY;
         H_READY: begin
            if (start) nx = H_HOLD;
            else if (sm_q && (tx_req || rx_req)) nx = H_SWAIT;
            else if (tx_req) nx = H_ATX;
         end
         H_ATX:    if (cnt_z && bit_q == 4'd9) nx = H_READY;
         H_SWAIT:  if (so_s) nx = H_SBURST;
         H_SBURST: if (cnt_z && bit_q == 4'd15) nx = H_READY;
         default:  nx = H_IDLE;
      endcase
   end

   wire [23:0] ld_val = (nx == H_HOLD)  ? 24'(`SBP_HOLD_CYC - 1) :
                        (nx == H_SETUP) ? 24'(SETUP_CYC - 1) :
                        (nx == H_ATX)   ? 24'(BAUD_DIV - 1) :
                                          24'(`SBP_SYNC_HALF_CYC - 1);
   wire take = (st_q == H_READY) && (nx == H_ATX || nx == H_SWAIT);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_q   <= H_IDLE;
         cnt_q  <= 24'h0;
         ready  <= 1'b0;
         sm_q   <= 1'b0;
         rpin_q <= 1'b0;
         mpin_q <= 1'b0;
      end else begin
         st_q   <= nx;
         ready  <= (nx == H_READY);
         cnt_q  <= (nx != st_q || cnt_z) ? ld_val : cnt_q - 24'h1;
         if (nx == H_HOLD) sm_q <= use_sync;
         rpin_q <= (nx != H_IDLE && nx != H_HOLD);
         mpin_q <= (nx != H_IDLE && nx != H_HOLD);
      end
   end

   // ==========================================================
   // Bit engine: asynchronous frames or clock bursts, clock idles high
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         bit_q  <= 4'h0;
         sh_q   <= 10'h3ff;
         rsh_q  <= 8'h00;
         rd_q   <= 1'b0;
         dout_q <= 1'b1;
         sclk_q <= 1'b1;
      end else if (take) begin
         bit_q <= 4'h0;
         rd_q  <= ~tx_req;
         sh_q  <= !tx_req ? 10'h3ff : sm_q ? {2'b11, tx_byte} : {1'b1, tx_byte, 1'b0};
      end else if (st_q == H_ATX) begin
         dout_q <= sh_q[0];
         if (cnt_z) begin
            sh_q  <= {1'b1, sh_q[9:1]};
            bit_q <= bit_q + 4'h1;
         end
      end else if (st_q == H_SBURST) begin
         if (cnt_z) begin
            sclk_q <= ~sclk_q;
            bit_q  <= bit_q + 4'h1;
            if (sclk_q) begin
               dout_q <= sh_q[0];
            end else begin
               sh_q  <= {1'b1, sh_q[9:1]};
               rsh_q <= {so_s, rsh_q[7:1]};
            end
         end
      end else begin
         dout_q <= 1'b1;
         sclk_q <= 1'b1;
      end
   end

   // ==========================================================
   // Asynchronous receiver at the host bit time
   logic        arun_q;
   logic [23:0] acnt_q;
   logic [3:0]  abit_q;
   logic [7:0]  ash_q;
   wire         sess   = !sm_q && (st_q == H_READY || st_q == H_ATX);
   wire         a_tick = arun_q && acnt_q == 24'h0;
   wire         b_done = st_q == H_SBURST && cnt_z && bit_q == 4'd15 && rd_q;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         so_q     <= 1'b1;
         arun_q   <= 1'b0;
         acnt_q   <= 24'h0;
         abit_q   <= 4'h0;
         ash_q    <= 8'h00;
         rx_valid <= 1'b0;
         rx_byte  <= 8'h00;
      end else begin
         so_q     <= so_s;
         rx_valid <= 1'b0;
         if (b_done) begin
            rx_valid <= 1'b1;
            rx_byte  <= {so_s, rsh_q[7:1]};
         end
         if (!sess) begin
            arun_q <= 1'b0;
         end else if (!arun_q) begin
            arun_q <= so_q & ~so_s;
            acnt_q <= 24'(BAUD_DIV / 2);
            abit_q <= 4'h0;
         end else if (a_tick) begin
            acnt_q <= 24'(BAUD_DIV - 1);
            abit_q <= abit_q + 4'h1;
            if ((abit_q == 4'd0 && so_s) || abit_q == 4'd9) arun_q <= 1'b0;
            if (abit_q != 4'd0 && abit_q != 4'd9) ash_q <= {so_s, ash_q[7:1]};
            if (abit_q == 4'd9 && so_s) begin
               rx_valid <= 1'b1;
               rx_byte  <= ash_q;
            end
         end else begin
            acnt_q <= acnt_q - 24'h1;
         end
      end
   end

   assign lnk.rst_pin_b     = rpin_q;
   assign lnk.mode_pin      = mpin_q;
   assign lnk.async_rx_pin  = dout_q;
   assign lnk.sync_clock_in = sclk_q;
endmodule : sbp_host

// [tb/sbp_asserts.sv]
// Checker of the device session outputs and the link pins.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ps
module sbp_asserts import sbp_pkg::*; #(parameter int CW = 18) (
   input wire logic    clk_link, rst_b, rst_pin_b, async_tx_pin, security_on, cmd_valid,
   input sbp_link_t    link_mode,
   input wire logic [CW-1:0] bit_cycles,
   input sbp_byte_t    cmd_code
);
   default clocking cb @(posedge clk_link); endclocking
   default disable iff (!rst_b);
   property p_hold;
      rst_pin_b [*4] ##0 ($past(link_mode) != SBP_LINK_NONE) |-> link_mode == $past(link_mode);
   endproperty
   a_hold: assert property (p_hold) else $error("link type changed in session");
   property p_sec;
      security_on |=> security_on;
   endproperty
   a_sec: assert property (p_sec) else $error("security cleared");
   property p_code;
      cmd_valid |-> cmd_code inside {8'hf0, 8'h30, 8'h40, 8'h60};
   endproperty
   a_code: assert property (p_code) else $error("bad handed-off command");
   property p_pulse;
      cmd_valid |=> !cmd_valid;
   endproperty
   a_pulse: assert property (p_pulse) else $error("command pulse too long");
   property p_link;
      cmd_valid |-> link_mode != SBP_LINK_NONE;
   endproperty
   a_link: assert property (p_link) else $error("command in standby");
   property p_off;
      !rst_pin_b [*4] |=> link_mode == SBP_LINK_NONE && !cmd_valid;
   endproperty
   a_off: assert property (p_off) else $error("session alive in pin reset");
   property p_rate;
      (link_mode == SBP_LINK_ASYNC) [*3] |-> $stable(bit_cycles) && bit_cycles != '0;
   endproperty
   a_rate: assert property (p_rate) else $error("bit time not kept");
   property p_quiet;
      (link_mode == SBP_LINK_NONE) [*2] |-> async_tx_pin;
   endproperty
   a_quiet: assert property (p_quiet) else $error("output in standby");
   c_sync: cover property (link_mode == SBP_LINK_SYNC);
   c_async: cover property (link_mode == SBP_LINK_ASYNC);
   c_cmd: cover property (cmd_valid);
   c_sec: cover property ($rose(security_on));
endmodule : sbp_asserts

// [tb/serial_boot_programming_port_tb_top.sv]
// Bench joining host and device ends over one link, random values from a fixed seed.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
   $display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module serial_boot_programming_port_tb_top;
   import sbp_pkg::*;
   logic clk_sys = 0, clk_link = 0, rst_b = 0, start = 0, use_sync = 0, tx_req = 0, rx_req = 0;
   logic ready, rx_valid, sec, cv, bd, bc, fh, rh;
   logic [15:0] flash_sum = '0, cpu_addr = '0, s;
   logic [14:0] fo;
   logic [17:0] bcy;
   logic [31:0] seed = 32'h0001699d;
   sbp_byte_t tx_byte = '0, rx_byte, ccode;
   sbp_link_t lm;
   int err_count = 0, num_checks = 0, ncmd = 0, i, n;
   sbp_byte_t ops[6] = '{8'hf0, 8'h30, 8'h40, 8'h60, 8'hd0, 8'hfa};
   logic [15:0] cor[12] = '{16'h0fff, 16'h1000, 16'h17ff, 16'h1800, 16'h1fff, 16'h2000,
                            16'h7fff, 16'h8000, 16'h005f, 16'h0060, 16'h083f, 16'h0840};
   initial forever #4 clk_sys = ~clk_sys;
   initial begin #3; forever #6 clk_link = ~clk_link; end
   always @(posedge clk_link) if (cv === 1'b1) ncmd++;
   sbp_link_if lnk ();
   sbp_host #(.SETUP_CYC(200), .BAUD_DIV(64)) sbp_host_i (.clk_sys, .rst_b, .start, .use_sync,
      .ready, .tx_req, .tx_byte, .rx_req, .rx_valid, .rx_byte, .lnk(lnk.host));
   sbp_dev sbp_dev_i (.clk_link, .rst_b, .lnk(lnk.dev), .link_mode(lm), .bit_cycles(bcy),
      .security_on(sec), .cmd_valid(cv), .cmd_code(ccode), .flash_sum, .cpu_addr,
      .brom_data_sel(bd), .brom_code_sel(bc), .flash_hit(fh), .flash_ofs(fo), .ram_hit(rh));
   sbp_asserts #(.CW(18)) sbp_asserts_i (.clk_link, .rst_b, .rst_pin_b(lnk.rst_pin_b),
      .async_tx_pin(lnk.async_tx_pin), .security_on(sec), .cmd_valid(cv), .link_mode(lm),
      .bit_cycles(bcy), .cmd_code(ccode));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [18:0] emap(logic [15:0] a);
      return {a >= 16'h1000 && a <= 16'h17ff, a >= 16'h1000 && a <= 16'h1fff, a >= 16'h8000,
              a >= 16'h0060 && a <= 16'h083f, a[14:0]};
   endfunction : emap
   task automatic xfer(sbp_byte_t b, logic rx);
      int k;
      k = 0;
      while (ready !== 1'b1 && k < 20000) begin k++; @(negedge clk_sys); end
      tx_req = !rx; rx_req = rx; tx_byte = b;
      @(negedge clk_sys); tx_req = 0; rx_req = 0;
   endtask : xfer
   task automatic get(sbp_byte_t e, sbp_byte_t m = 8'hff);
      int k;
      k = 0;
      while (rx_valid !== 1'b1 && k < 8000) begin k++; @(negedge clk_sys); end
      `CHK({rx_valid, rx_byte & m}, {1'b1, e})
      @(negedge clk_sys);
   endtask : get
   task automatic sess(logic y);
      use_sync = y; start = 1; @(negedge clk_sys); start = 0;
   endtask : sess
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize
   initial begin #600_000; err_count++; summarize(); end
   initial begin
      repeat (6) @(negedge clk_sys);
      rst_b = 1; sess(0); xfer(8'h55, 0);
      repeat (1500) @(negedge clk_sys);
      `CHK(lm, SBP_LINK_NONE)
      xfer(8'h86, 0); get(8'h86);
      `CHK(lm, SBP_LINK_ASYNC)
      // Bit time is 64 * 8 ns over a 12 ns link clock, about 42.7 cycles.
      `CHK(bcy inside {[18'd41:18'd44]}, 1'b1)
      for (i = 0; i < 6; i++) begin
         n = ncmd; xfer(ops[i], 0); get(ops[i]);
         repeat (20) @(negedge clk_sys);
         `CHK(ncmd - n, int'(i < 4))
         `CHK(ccode, ops[i])
      end
      `CHK(sec, 1'b1)
      xfer(8'hc0, 0); get(8'hc0); get(8'h5a); get(8'ha5);
      s = rnd(); flash_sum = s; xfer(8'h90, 0); get(8'hff); get(s[15:8]); get(s[7:0]);
      $display("async session done");
      for (i = 0; i < 20; i++) begin
         s = (i < 12) ? cor[i] : rnd(); cpu_addr = s;
         repeat (3) @(posedge clk_link); #1;
         `CHK({bd, bc, fh, rh, fo}, emap(s))
         @(negedge clk_sys);
      end
      $display("address map done");
      sess(1); xfer(8'h30, 0); xfer(8'hff, 1); get(8'h30);
      repeat (20) @(negedge clk_sys);
      `CHK(lm, SBP_LINK_SYNC)
      `CHK(lnk.async_tx_pin, 1'b1)
      xfer(8'hc3, 0); xfer(8'hff, 1); get(8'hc3); xfer(8'hff, 1); get(8'h01, 8'h01);
      $display("sync session done");
      summarize();
   end
endmodule : serial_boot_programming_port_tb_top
